/* File: hw/slcr_laser_test.sv */
// Laser drive pin fault tester and normal pin driver.
// Assumes start is a one-cycle pulse on the same clock; sense comes from the pin.
`timescale 1ns/1ns
module slcr_laser_test #(
  parameter int unsigned PULSE_CYC = slcr_pkg::LASER_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic start_i,
  input wire logic drive_req_i,
  input wire logic sense_i,
  // Pins and status
  output logic drive_o,
  output logic enable_n_o,
  output logic fault_o,
  output logic testing_o
);

  // ****************************************
  // Checks and state
  // ****************************************
  // Pulse length must fit the phase counter
  if (PULSE_CYC < 1 || PULSE_CYC >= (1 << slcr_pkg::LASER_CNT_W)) begin : g_bad_pulse
    $error("PULSE_CYC out of range");
  end

  localparam logic [slcr_pkg::LASER_CNT_W-1:0] LAST =
    slcr_pkg::LASER_CNT_W'(PULSE_CYC - 1);

  typedef struct packed {
    logic [1:0] sense_s;
    slcr_pkg::slcr_lt_state_t state;
    logic [slcr_pkg::LASER_CNT_W-1:0] cnt;
    logic drive;
    logic enable_n;
    logic fault;
  } slcr_lt_t;

  slcr_lt_t s_r;
  slcr_lt_t s_nxt;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.sense_s = {s_r.sense_s[0], sense_i};
    s_nxt.cnt = s_r.cnt + 1'b1;
    unique case (s_r.state)
      slcr_pkg::SLCR_LT_NORMAL: begin
        s_nxt.cnt = '0;
      end
      // (R15) high pulse phase
      slcr_pkg::SLCR_LT_HIGH: begin
        if (s_r.cnt == LAST) begin
          s_nxt.cnt = '0;
          // (R14) stuck low check
          s_nxt.state = s_r.sense_s[1] ? slcr_pkg::SLCR_LT_LOW : slcr_pkg::SLCR_LT_FAULT;
        end
      end
      // (R15) low pulse phase
      slcr_pkg::SLCR_LT_LOW: begin
        if (s_r.cnt == LAST) begin
          s_nxt.cnt = '0;
          // (R14) stuck high check
          s_nxt.state = s_r.sense_s[1] ? slcr_pkg::SLCR_LT_FAULT : slcr_pkg::SLCR_LT_NORMAL;
        end
      end
      slcr_pkg::SLCR_LT_FAULT: begin
        s_nxt.cnt = '0;
      end
    endcase
    // (R14) any laser config write restarts test
    if (start_i) begin
      s_nxt.state = slcr_pkg::SLCR_LT_HIGH;
      s_nxt.cnt = '0;
    end
    // Registered pin levels for the coming state
    unique case (s_nxt.state)
      slcr_pkg::SLCR_LT_NORMAL: begin
        s_nxt.drive = drive_req_i;
        s_nxt.enable_n = 1'b0;
      end
      slcr_pkg::SLCR_LT_HIGH: begin
        s_nxt.drive = 1'b1;
        s_nxt.enable_n = 1'b1;
      end
      slcr_pkg::SLCR_LT_LOW: begin
        s_nxt.drive = 1'b0;
        s_nxt.enable_n = 1'b1;
      end
      slcr_pkg::SLCR_LT_FAULT: begin
        s_nxt.drive = 1'b0;
        s_nxt.enable_n = 1'b1;
      end
    endcase
    // (R18) latched fault
    s_nxt.fault = (s_nxt.state == slcr_pkg::SLCR_LT_FAULT);
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '{sense_s: 2'h0, state: slcr_pkg::SLCR_LT_NORMAL, cnt: '0,
               drive: 1'b0, enable_n: 1'b0, fault: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign drive_o = s_r.drive;
  assign enable_n_o = s_r.enable_n;
  assign fault_o = s_r.fault;
  assign testing_o = (s_r.state == slcr_pkg::SLCR_LT_HIGH) || (s_r.state == slcr_pkg::SLCR_LT_LOW);

endmodule

/* File: hw/slcr_pkg.sv */
// Constants shared by the shutter and laser configuration register block.
// Assumes a 10 MHz core clock and a four-wire serial port from a controller.
package slcr_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_FREQ_KHZ = 10000;
  // Laser pin test pulse length, high and low phase each
  localparam int unsigned LASER_PULSE_NS = 12000;
  localparam int unsigned LASER_PULSE_CYC_RAW = (LASER_PULSE_NS * CLK_FREQ_KHZ) / 1000000;
  localparam int unsigned LASER_PULSE_CYC = (LASER_PULSE_CYC_RAW < 1) ? 1 : LASER_PULSE_CYC_RAW;
  localparam int unsigned LASER_CNT_W = 8;
  // Frame ticks the busy flag stands after a bound commit
  localparam logic [1:0] BUSY_FRAMES = 2'h2;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [6:0] ADDR_SILICON_REV = 7'h01;
  localparam logic [6:0] ADDR_FRAME_MAX_UPPER = 7'h1A;
  localparam logic [6:0] ADDR_SHUT_LO = 7'h1D;
  localparam logic [6:0] ADDR_SHUT_HI = 7'h1E;
  localparam logic [6:0] ADDR_FW_REV = 7'h1F;
  localparam logic [6:0] ADDR_LASER_CFG = 7'h2C;
  localparam logic [6:0] ADDR_LASER_CMP = 7'h2D;

  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [7:0] SHUT_LO_RST = 8'h20;
  localparam logic [7:0] SHUT_HI_RST = 8'h4E;
  localparam logic [7:0] LASER_CFG_RST = 8'h7F;
  localparam logic [7:0] LASER_CMP_RST = 8'h80;
  localparam int unsigned LASER_MATCH_BIT = 7;
  localparam int unsigned SPI_WRITE_BIT = 7;
  // Largest code, lowest relative laser current
  localparam logic [6:0] LASER_CODE_MIN = 7'h7F;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic {SLCR_SP_ADDR, SLCR_SP_DATA} slcr_spi_phase_t;
  typedef enum logic [1:0] {SLCR_LT_NORMAL, SLCR_LT_HIGH, SLCR_LT_LOW, SLCR_LT_FAULT}
    slcr_lt_state_t;

endpackage

/* File: hw/slcr_regs.sv */
// Shutter limit, firmware revision and laser drive configuration registers.
// Assumes a controller on the four-wire serial port, idle-high serial clock,
// data sampled on rising edges, address byte (bit 7 set for write) then data.
//
// Summary of operation
// (R1) Auto exposure never exceeds shutter limit
// (R2) Shutter limit is two-byte 16-bit value
// (R3) Controller reads upper byte before lower
// (R4) Controller writes lower, upper, then bound
// (R5) Manual exposure uses the limit directly
// (R6) Reads immediate; use waits for bound write
// (R7) Controller waits two frames before rewriting
// (R8) Busy shown while new bounds apply
// (R9) Controller keeps frame bounds consistent
// (R10) Firmware revision reads zero unless running
// (R11) Silicon revision has its own register
// (R12) Bit 7 match, bits 6-0 DAC
// (R13) Each code step lowers current slightly
// (R14) Laser config write starts pin test
// (R15) Test: enable high, pin pulses high, low
// (R16) Bad complement forces minimum laser current
// (R17) Laser pair writable in either order
// (R18) Fault keeps laser off, latched
// (R19) Unmapped bits zero, read-only writes ignored
`timescale 1ns/1ns
module slcr_regs #(
  // Arbitrary value, no meaning
  parameter logic [7:0] SILICON_REV = 8'h5A
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Serial port
  input wire logic NCS_N_I,
  input wire logic SCLK_I,
  input wire logic MOSI_I,
  output logic MISO_O,
  output logic MISO_OE_O,
  // Firmware status
  input wire logic DOWNLOADED_FIRMWARE_OK_I,
  input wire logic [7:0] DOWNLOADED_FIRMWARE_REV_I,
  // Exposure control
  input wire logic AUTO_EXPOSURE_CONTROL_I,
  input wire logic [15:0] SHUTTER_REQ_I,
  input wire logic FRAME_TICK_I,
  output logic [15:0] SHUTTER_O,
  output logic BUSY_O,
  // Laser
  input wire logic LASER_DRV_REQ_I,
  input wire logic LASER_SENSE_I,
  output logic LASER_DRIVE_PIN_O,
  output logic LASER_ENABLE_N_PIN_O,
  output logic [6:0] LASER_CURRENT_CODE_O,
  output logic LASER_MATCH_O,
  output logic LASER_FAULT_O,
  output logic LASER_TEST_O
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Busy count needs at least one frame
  if (slcr_pkg::BUSY_FRAMES == 2'h0) begin : g_bad_busy
    $error("BUSY_FRAMES must be nonzero");
  end
  // Match bit must sit above the 7-bit code
  if (slcr_pkg::LASER_MATCH_BIT != 7) begin : g_bad_match
    $error("LASER_MATCH_BIT must be 7");
  end

  // ****************************************
  // Register map
  // ****************************************
  // Address byte bit 7 set marks a write
  // 01 silicon revision, read only
  // 1A bound commit, data not kept
  // 1D, 1E staged shutter limit bytes
  // 1F firmware revision, read only
  // 2C laser config, write starts pin test
  // 2D laser complement
  // Other addresses read zero, writes dropped

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] ncs_s;
    logic [1:0] mosi_s;
    slcr_pkg::slcr_spi_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [6:0] addr;
    logic wr;
    logic [7:0] tx;
    logic [7:0] shut_lo;
    logic [7:0] shut_hi;
    logic [15:0] shut_act;
    logic [1:0] busy_cnt;
    logic busy;
    logic [7:0] las_cfg;
    logic [7:0] las_cmp;
    logic test_start;
    logic [15:0] shutter;
    logic [6:0] laser_code;
    logic laser_match;
  } slcr_regs_t;

  slcr_regs_t s_r;
  slcr_regs_t s_nxt;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic [7:0] rx_shift;
  // High in the cycle a bound write commits the limit
  logic commit;

  // ****************************************
  // Read decode
  // ****************************************
  function automatic logic [7:0] read_mux(input logic [6:0] a, input slcr_regs_t s,
                                          input logic fw_ok, input logic [7:0] fw_rev);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      // (R11) silicon revision register
      slcr_pkg::ADDR_SILICON_REV: d = SILICON_REV;
      // (R6) staged value reads back
      slcr_pkg::ADDR_SHUT_LO: d = s.shut_lo;
      slcr_pkg::ADDR_SHUT_HI: d = s.shut_hi;
      // (R10) revision only when running
      slcr_pkg::ADDR_FW_REV: d = fw_ok ? fw_rev : 8'h00;
      slcr_pkg::ADDR_LASER_CFG: d = s.las_cfg;
      slcr_pkg::ADDR_LASER_CMP: d = s.las_cmp;
      // (R19) unmapped reads zero
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // ****************************************
  // Serial pin decode
  // ****************************************
  // Edge detect on the synchronised serial clock
  assign sclk_rise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
  assign sclk_fall = ~s_r.sclk_s[1] & s_r.sclk_s[2];
  assign cs_active = ~s_r.ncs_s[1];
  assign rx_shift = {s_r.rx[6:0], s_r.mosi_s[1]};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.test_start = 1'b0;
    commit = 1'b0;
    // Two-flop synchronisers for the serial pins
    s_nxt.sclk_s = {s_r.sclk_s[1:0], SCLK_I};
    s_nxt.ncs_s = {s_r.ncs_s[0], NCS_N_I};
    s_nxt.mosi_s = {s_r.mosi_s[0], MOSI_I};

    // Serial receive and transmit
    if (!cs_active) begin
      s_nxt.phase = slcr_pkg::SLCR_SP_ADDR;
      s_nxt.bit_cnt = 3'h0;
      s_nxt.tx = 8'h00;
    end else if (sclk_rise) begin
      s_nxt.rx = rx_shift;
      s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
      if (s_r.bit_cnt == 3'h7) begin
        if (s_r.phase == slcr_pkg::SLCR_SP_ADDR) begin
          s_nxt.addr = rx_shift[6:0];
          s_nxt.wr = rx_shift[slcr_pkg::SPI_WRITE_BIT];
          s_nxt.phase = slcr_pkg::SLCR_SP_DATA;
          s_nxt.tx = rx_shift[slcr_pkg::SPI_WRITE_BIT] ? 8'h00 :
            read_mux(rx_shift[6:0], s_r, DOWNLOADED_FIRMWARE_OK_I, DOWNLOADED_FIRMWARE_REV_I);
        end else begin
          s_nxt.phase = slcr_pkg::SLCR_SP_ADDR;
          s_nxt.tx = 8'h00;
          if (s_r.wr) begin
            // (R19) read-only and unmapped writes dropped
            unique case (s_r.addr)
              // (R2) staged 16-bit limit bytes
              slcr_pkg::ADDR_SHUT_LO: s_nxt.shut_lo = rx_shift;
              slcr_pkg::ADDR_SHUT_HI: s_nxt.shut_hi = rx_shift;
              // (R6) bound write commits limit
              slcr_pkg::ADDR_FRAME_MAX_UPPER: begin
                s_nxt.shut_act = {s_r.shut_hi, s_r.shut_lo};
                commit = 1'b1;
                // (R8) busy while applying
                s_nxt.busy = 1'b1;
                s_nxt.busy_cnt = 2'h0;
              end
              // (R14) launch pin test
              slcr_pkg::ADDR_LASER_CFG: begin
                s_nxt.las_cfg = rx_shift;
                s_nxt.test_start = 1'b1;
              end
              // (R17) either order accepted
              slcr_pkg::ADDR_LASER_CMP: s_nxt.las_cmp = rx_shift;
              default: begin
              end
            endcase
          end
        end
      end
    end else if (sclk_fall && s_r.phase == slcr_pkg::SLCR_SP_DATA && s_r.bit_cnt != 3'h0) begin
      // Next read bit after each sampled rising edge
      s_nxt.tx = {s_r.tx[6:0], 1'b0};
    end

    // (R8) busy clears after two frames, a fresh commit restarts the count
    if (s_r.busy && FRAME_TICK_I && !commit) begin
      if (s_r.busy_cnt == slcr_pkg::BUSY_FRAMES - 2'h1) begin
        s_nxt.busy = 1'b0;
      end else begin
        s_nxt.busy_cnt = s_r.busy_cnt + 2'h1;
      end
    end

    // (R1) auto mode clamps to limit
    if (AUTO_EXPOSURE_CONTROL_I) begin
      s_nxt.shutter = (SHUTTER_REQ_I > s_r.shut_act) ? s_r.shut_act : SHUTTER_REQ_I;
    end else begin
      // (R5) manual mode uses limit
      s_nxt.shutter = s_r.shut_act;
    end

    // (R16) complement check on pair
    if (s_r.las_cmp == ~s_r.las_cfg) begin
      // (R12) DAC code from low bits
      s_nxt.laser_code = s_r.las_cfg[6:0];
    end else begin
      // (R13) largest code, minimum current
      s_nxt.laser_code = slcr_pkg::LASER_CODE_MIN;
    end
    // (R12) bin match bit
    s_nxt.laser_match = s_r.las_cfg[slcr_pkg::LASER_MATCH_BIT];
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_r <= '{
        sclk_s: 3'h7,
        ncs_s: 2'h3,
        mosi_s: 2'h0,
        phase: slcr_pkg::SLCR_SP_ADDR,
        bit_cnt: 3'h0,
        rx: 8'h00,
        addr: 7'h00,
        wr: 1'b0,
        tx: 8'h00,
        shut_lo: slcr_pkg::SHUT_LO_RST,
        shut_hi: slcr_pkg::SHUT_HI_RST,
        shut_act: {slcr_pkg::SHUT_HI_RST, slcr_pkg::SHUT_LO_RST},
        busy_cnt: 2'h0,
        busy: 1'b0,
        las_cfg: slcr_pkg::LASER_CFG_RST,
        las_cmp: slcr_pkg::LASER_CMP_RST,
        test_start: 1'b0,
        shutter: {slcr_pkg::SHUT_HI_RST, slcr_pkg::SHUT_LO_RST},
        laser_code: slcr_pkg::LASER_CFG_RST[6:0],
        laser_match: slcr_pkg::LASER_CFG_RST[slcr_pkg::LASER_MATCH_BIT]
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Laser pin tester
  // ****************************************
  // (R15) pulse sequence and pin control
  slcr_laser_test #(
    .PULSE_CYC(slcr_pkg::LASER_PULSE_CYC)
  ) u_laser_test (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .start_i(s_r.test_start),
    .drive_req_i(LASER_DRV_REQ_I),
    .sense_i(LASER_SENSE_I),
    .drive_o(LASER_DRIVE_PIN_O),
    .enable_n_o(LASER_ENABLE_N_PIN_O),
    .fault_o(LASER_FAULT_O),
    .testing_o(LASER_TEST_O)
  );

  // ****************************************
  // Outputs
  // ****************************************
  // Serial data out, driven while selected
  assign MISO_O = s_r.tx[7];
  assign MISO_OE_O = cs_active;
  // Exposure and laser settings
  assign SHUTTER_O = s_r.shutter;
  assign BUSY_O = s_r.busy;
  assign LASER_CURRENT_CODE_O = s_r.laser_code;
  assign LASER_MATCH_O = s_r.laser_match;

endmodule

/* File: test/slcr_host_mdl.sv */
// Controller model on the four-wire serial port, clock idle high.
// Tasks are called by the bench at a falling core clock edge.
`timescale 1ns/1ns
module slcr_host_mdl (
  // Serial pins
  output logic ncs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i,
  // Device status
  input wire logic busy_i
);
  // Idle: deselected, clock high
  initial begin
    ncs_n_o = 1'b1;
    sclk_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Address and data byte, data in sampled at each rise
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] sh;
    sh = {a, d};
    q = 8'h00;
    ncs_n_o = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = sh[i];
      #400;
      q = {q[6:0], miso_i};
      sclk_o = 1'b1;
      #400;
    end
    ncs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line shows no stale bit
    #800;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer({1'b1, a}, d, q);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    xfer({1'b0, a}, 8'h00, q);
  endtask
  // stage limit once busy clears, lower first
  task automatic stage(input logic [15:0] v, output logic ok);
    repeat (500) if (busy_i) #100;
    ok = !busy_i;
    wr(7'h1D, v[7:0]);
    wr(7'h1E, v[15:8]);
  endtask
  // commit with the largest frame period
  task automatic commit();
    wr(7'h1A, 8'hFF);
  endtask
  task automatic lim_rd(output logic [15:0] v);
    rd(7'h1E, v[15:8]);
    rd(7'h1D, v[7:0]);
  endtask
endmodule

/* File: test/slcr_regs_chk.sv */
// Port assertions for the shutter and laser register block.
// Bound into every slcr_regs instance; sees only that module's ports.
`timescale 1ns/1ns
module slcr_regs_chk (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Exposure
  input wire logic AUTO_EXPOSURE_CONTROL_I,
  input wire logic [15:0] SHUTTER_REQ_I,
  input wire logic [15:0] SHUTTER_O,
  input wire logic BUSY_O,
  input wire logic FRAME_TICK_I,
  // Laser
  input wire logic LASER_DRV_REQ_I,
  input wire logic LASER_DRIVE_PIN_O,
  input wire logic LASER_ENABLE_N_PIN_O,
  input wire logic LASER_FAULT_O,
  input wire logic LASER_TEST_O
);
  // ****************************************
  // Helper logic and properties
  // ****************************************
  logic [7:0] hi_run_r;
  logic [7:0] hi_run_nxt;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // Length of the current test high phase
  always_comb begin
    hi_run_nxt = (LASER_TEST_O && LASER_DRIVE_PIN_O) ? hi_run_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hi_run_r <= 8'h00;
    end else begin
      hi_run_r <= hi_run_nxt;
    end
  end
  sequence s_manual_quiet;
    (!AUTO_EXPOSURE_CONTROL_I && !BUSY_O) [*3];
  endsequence
  sequence s_test_pins;
    LASER_DRIVE_PIN_O && LASER_ENABLE_N_PIN_O;
  endsequence
  AST_AUTO_LIMIT: assert property (
    AUTO_EXPOSURE_CONTROL_I |=> SHUTTER_O <= $past(SHUTTER_REQ_I)) else $error("shutter above request");
  AST_MANUAL_HOLD: assert property (
    s_manual_quiet |-> $stable(SHUTTER_O)) else $error("shutter moved without commit");
  AST_TEST_ENTRY: assert property (
    $rose(LASER_TEST_O) |-> s_test_pins) else $error("test did not start high");
  AST_HIGH_LEN: assert property (
    LASER_TEST_O && $fell(LASER_DRIVE_PIN_O) |-> hi_run_r == slcr_pkg::LASER_PULSE_CYC)
    else $error("test high phase length wrong");
  AST_TEST_END: assert property (
    $fell(LASER_TEST_O) |-> LASER_FAULT_O == LASER_ENABLE_N_PIN_O) else $error("bad pins after test");
  AST_FAULT_OFF: assert property (
    LASER_FAULT_O && !LASER_TEST_O |-> LASER_ENABLE_N_PIN_O && !LASER_DRIVE_PIN_O)
    else $error("laser on during fault");
  AST_FAULT_CLEAR: assert property (
    $fell(LASER_FAULT_O) |-> ##[0:3] LASER_TEST_O) else $error("fault cleared without write");
  AST_BUSY_HOLD: assert property (
    BUSY_O && !FRAME_TICK_I |=> BUSY_O) else $error("busy dropped between frames");
  AST_BUSY_FALL: assert property (
    $fell(BUSY_O) |-> $past(FRAME_TICK_I)) else $error("busy fell without frame tick");
  AST_DRIVE_FOLLOW: assert property (
    !LASER_TEST_O && !LASER_FAULT_O && !LASER_ENABLE_N_PIN_O |->
    LASER_DRIVE_PIN_O == $past(LASER_DRV_REQ_I)) else $error("drive pin not following request");
endmodule

bind slcr_regs slcr_regs_chk u_chk (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .AUTO_EXPOSURE_CONTROL_I(AUTO_EXPOSURE_CONTROL_I),
  .SHUTTER_REQ_I(SHUTTER_REQ_I), .SHUTTER_O(SHUTTER_O), .BUSY_O(BUSY_O),
  .FRAME_TICK_I(FRAME_TICK_I), .LASER_DRV_REQ_I(LASER_DRV_REQ_I),
  .LASER_DRIVE_PIN_O(LASER_DRIVE_PIN_O), .LASER_ENABLE_N_PIN_O(LASER_ENABLE_N_PIN_O),
  .LASER_FAULT_O(LASER_FAULT_O), .LASER_TEST_O(LASER_TEST_O));

/* File: test/slcr_regs_tb.sv */
// Self-checking bench for slcr_regs with a serial controller model.
// Expected values come from an integer register model kept here.
`timescale 1ns/1ns
module slcr_regs_tb;
  localparam logic [7:0] SREV = 8'h3C; // Arbitrary value
  logic clk, nrst, ncs_n, sclk, mosi, miso, oe, miso_w, fw_ok, auto_en, tick, req_d;
  logic sense, drive, en_n, match, fault, test, busy, ok;
  logic [1:0] stuck;
  logic [6:0] code;
  logic [7:0] fw_rev, d;
  logic [15:0] req, shut, rv;
  int mdl [128];
  int err_total = 0;
  int comparisons = 0;
  int tcnt = 0;
  logic [6:0] addrs [7] = '{7'h1D, 7'h1E, 7'h2C, 7'h2D, 7'h1F, 7'h01, 7'h30};
  slcr_regs #(.SILICON_REV(SREV)) dut (
    .CLK_I(clk), .NRST_I(nrst), .NCS_N_I(ncs_n), .SCLK_I(sclk), .MOSI_I(mosi),
    .MISO_O(miso), .MISO_OE_O(oe), .DOWNLOADED_FIRMWARE_OK_I(fw_ok),
    .DOWNLOADED_FIRMWARE_REV_I(fw_rev), .AUTO_EXPOSURE_CONTROL_I(auto_en),
    .SHUTTER_REQ_I(req), .FRAME_TICK_I(tick), .SHUTTER_O(shut), .BUSY_O(busy),
    .LASER_DRV_REQ_I(req_d), .LASER_SENSE_I(sense), .LASER_DRIVE_PIN_O(drive),
    .LASER_ENABLE_N_PIN_O(en_n), .LASER_CURRENT_CODE_O(code), .LASER_MATCH_O(match),
    .LASER_FAULT_O(fault), .LASER_TEST_O(test));
  slcr_host_mdl u_host (.ncs_n_o(ncs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso_w),
    .busy_i(busy));
  // Pin readback with optional stuck level; data line pulled up when released
  assign sense = stuck[1] | (~stuck[0] & drive);
  assign miso_w = oe ? miso : 1'b1;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Frame tick every 40 cycles, random laser drive request outside reset
  always @(negedge clk) begin
    tcnt <= tcnt + 1;
    tick <= (tcnt % 40 == 39);
    req_d <= nrst & 1'($urandom_range(0, 1));
  end
  task automatic chk(input string what, input int exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp[15:0]) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp[15:0], got);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Test must be running, then end within bound
  task automatic wait_test();
    int n;
    chk("test running", 1, {15'h0000, test});
    for (n = 0; n < 300 && test; n++) @(negedge clk);
    if (test) begin
      chk("test end", 0, {15'h0000, test});
      results();
    end
  endtask
  initial begin
    int v, c, lim;
    void'($urandom(32'hA416));
    nrst = 1'b0;
    {fw_ok, auto_en} = 2'h0;
    fw_rev = 8'h00;
    req = 16'h0000;
    stuck = 2'b00;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[8'h1D] = 8'h20;
    mdl[8'h1E] = 8'h4E;
    mdl[8'h2C] = 8'h7F;
    mdl[8'h2D] = 8'h80;
    mdl[8'h01] = SREV;
    lim = 16'h4E20;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    // Reset values, revisions and an unmapped address
    foreach (addrs[i]) begin
      u_host.rd(addrs[i], d);
      chk("reg read", mdl[addrs[i]], {8'h00, d});
    end
    chk("reset code", 8'h7F, {9'h000, code});
    // Firmware revision only while running downloaded code
    fw_rev = 8'($urandom_range(1, 255));
    u_host.wr(7'h1F, ~fw_rev);
    u_host.rd(7'h1F, d);
    chk("fw rev off", 0, {8'h00, d});
    fw_ok = 1'b1;
    u_host.rd(7'h1F, d);
    chk("fw rev on", fw_rev, {8'h00, d});
    // Laser pair in both orders, one broken complement
    for (int k = 0; k < 4; k++) begin
      v = $urandom_range(0, 255);
      c = (k == 2) ? v ^ 1 : (~v & 255);
      if (k[0]) u_host.wr(7'h2D, 8'(c));
      u_host.wr(7'h2C, 8'(v));
      if (!k[0]) u_host.wr(7'h2D, 8'(c));
      mdl[8'h2C] = v;
      mdl[8'h2D] = c;
      wait_test();
      chk("code", (c == (~v & 255)) ? v & 127 : 127, {9'h000, code});
      chk("match", v >> 7, {15'h0000, match});
      u_host.rd(7'h2C, d);
      chk("cfg read", v, {8'h00, d});
    end
    // Stuck low then stuck high, then a clean retest
    for (int s = 1; s < 4; s++) begin
      stuck = (s == 3) ? 2'b00 : 2'(s);
      u_host.wr(7'h2C, 8'(mdl[8'h2C]));
      wait_test();
      chk("fault", s != 3, {15'h0000, fault});
      chk("enable off", s != 3, {15'h0000, en_n});
    end
    // Staged limit, commit, busy, then auto exposure clamp
    for (int j = 0; j < 2; j++) begin
      auto_en = 1'b0;
      v = $urandom_range(1, 65535);
      u_host.stage(16'(v), ok);
      chk("busy wait", 1, {15'h0000, ok});
      if (!ok) results();
      u_host.lim_rd(rv);
      chk("staged read", v, rv);
      chk("old limit", lim, shut);
      u_host.commit();
      lim = v;
      repeat (3) @(negedge clk);
      chk("busy", 1, {15'h0000, busy});
      chk("new limit", lim, shut);
      auto_en = 1'b1;
      for (int r = 0; r < 4; r++) begin
        req = (r == 0) ? 16'hFFFF : 16'($urandom);
        repeat (2) @(negedge clk);
        chk("auto shutter", (req < lim) ? req : lim, shut);
      end
    end
    for (int n = 0; n < 200 && busy; n++) @(negedge clk);
    chk("busy clear", 0, {15'h0000, busy});
    if (busy) results();
    // Second reset in mid-run
    auto_en = 1'b0;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("limit after reset", 16'h4E20, shut);
    chk("code after reset", 8'h7F, {9'h000, code});
    results();
  end
endmodule
